//--- design/bitfield_extend_datapath.v
// Purpose: Bitfield clear/insert/extract and byte/half extend slice with sticky saturation bit
// Assumes: Operands come from the decoder already free of stack pointer and PC
// Notes: The result is combinational so writeback sees it in the issue cycle;
// Notes: op_result_valid is also combinational; every other output is registered. APB answers with one wait state.
`timescale 1ns/1ps
`include "bfx_consts.vh"
module bitfield_extend_datapath #(
	parameter DATA_W = 32
) (
	input  wire                sys_clk,
	input  wire                resetn,
	input  wire                op_valid,
	input  wire [`OPC_W-1:0]   op_code,
	input  wire [DATA_W-1:0]   source_operand,
	input  wire [DATA_W-1:0]   dest_operand,
	input  wire [DATA_W-1:0]   extend_source_operand,
	input  wire [4:0]          field_lsb,
	input  wire [5:0]          field_width,
	input  wire [1:0]          rotate_right_amount,
	output reg  [DATA_W-1:0]   op_result,
	output wire                op_result_valid,
	input  wire                clamp_valid,
	input  wire                clamp_saturated,
	input  wire                status_write_op,
	input  wire [`PSR_W-1:0]   status_write_data,
	output wire [`PSR_W-1:0]   program_status_flags,
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [7:0]          paddr,
	input  wire [31:0]         pwdata,
	output wire [31:0]         prdata,
	output wire                pready,
	output wire                pslverr,
	output wire                irq
);
	reg  [`PSR_W-1:0]  psr_reg;
	reg  [`PSR_W-1:0]  psr_next;
	reg  [`EVT_W-1:0]  evt_status_reg;
	reg  [`EVT_W-1:0]  evt_status_next;
	reg  [`EVT_W-1:0]  evt_mask_reg;
	reg  [DATA_W-1:0]  last_result_reg;
	reg                irq_reg;
	reg                pready_reg;
	reg                pslverr_reg;
	reg  [31:0]        prdata_reg;
	reg                valid_reg;
	wire [DATA_W-1:0]  field_mask;
	wire               field_bad;
	wire [DATA_W-1:0]  extend_result;
	wire [DATA_W-1:0]  field_shifted;
	wire [DATA_W-1:0]  insert_bits;
	wire [DATA_W-1:0]  extract_raw;
	wire [DATA_W-1:0]  extract_keep;
	wire [5:0]         top_index;
	wire               extract_sign;
	wire               is_field_op;
	wire               is_half;
	wire               is_signed;
	wire               apb_access;
	wire               apb_write;
	wire               apb_read;
	wire               psr_sel;
	wire               addr_ok;
	wire               clamp_event;

	// Field position decode is shared by clear, insert and extract
	function is_field_code;
		input [`OPC_W-1:0] code;
		begin
			is_field_code = (code == `OPC_FIELD_CLEAR) || (code == `OPC_FIELD_INSERT) ||
				(code == `OPC_SIGNED_FIELD_EXTRACT) || (code == `OPC_UNSIGNED_FIELD_EXTRACT);
		end
	endfunction

	function addr_mapped;
		input [7:0] addr;
		begin
			addr_mapped = (addr == `ADDR_PSR) || (addr == `ADDR_EVT_STATUS) ||
				(addr == `ADDR_EVT_MASK) || (addr == `ADDR_LAST_RESULT);
		end
	endfunction

	field_mask_gen #(
		.DATA_W      (DATA_W)
	) u_mask (
		.field_lsb   (field_lsb),
		.field_width (field_width),
		.field_mask  (field_mask),
		.field_bad   (field_bad)
	);

	rotate_extend u_ext (
		.extend_source_operand (extend_source_operand),
		.rotate_right_amount   (rotate_right_amount),
		.extend_half           (is_half),
		.extend_signed         (is_signed),
		.extend_result         (extend_result)
	);

	assign is_field_op = is_field_code(op_code);
	assign is_half     = (op_code == `OPC_SIGNED_HALF_EXTEND) || (op_code == `OPC_UNSIGNED_HALF_EXTEND);
	assign is_signed   = (op_code == `OPC_SIGNED_HALF_EXTEND) || (op_code == `OPC_SIGNED_BYTE_EXTEND);

	// Insert takes source bits from bit 0 upward and moves them to the start
	assign field_shifted = source_operand << field_lsb;
	assign insert_bits   = field_shifted & field_mask;
	// Extract brings the field down to bit 0 and keeps width bits
	assign extract_raw   = source_operand >> field_lsb;
	assign extract_keep  = field_mask >> field_lsb;
	assign top_index     = field_width - 6'h01;
	assign extract_sign  = extract_raw[top_index[4:0]];

	// Same-cycle result for writeback; only last_result_reg keeps a registered copy of it
	always @* begin
		case (op_code)
			`OPC_FIELD_CLEAR: begin
				op_result = dest_operand & ~field_mask;
			end
			`OPC_FIELD_INSERT: begin
				op_result = (dest_operand & ~field_mask) | insert_bits;
			end
			`OPC_SIGNED_FIELD_EXTRACT: begin
				op_result = (extract_raw & extract_keep) | ({DATA_W{extract_sign}} & ~extract_keep);
			end
			`OPC_UNSIGNED_FIELD_EXTRACT: begin
				op_result = extract_raw & extract_keep;
			end
			`OPC_SIGNED_BYTE_EXTEND,
			`OPC_UNSIGNED_BYTE_EXTEND,
			`OPC_SIGNED_HALF_EXTEND,
			`OPC_UNSIGNED_HALF_EXTEND: begin
				op_result = extend_result;
			end
			default: begin
				op_result = {DATA_W{1'b0}};
			end
		endcase
	end

	assign op_result_valid = op_valid && (op_code != `OPC_NONE);

	// Flag state: only the decoder's status write, an APB write to the PSR and a clamp touch it
	assign clamp_event = clamp_valid && clamp_saturated;

	always @* begin
		psr_next = psr_reg;
		if (status_write_op) begin
			psr_next = status_write_data;
		end
		if (apb_write && psr_sel) begin
			psr_next = pwdata[`PSR_W-1:0];
		end
		// Set beats a clear arriving in the same cycle; nzcv left alone by clamps
		if (clamp_event) begin
			psr_next[`PSR_Q_BIT] = 1'b1;
		end
		// Field and extend ops have no path into psr_next at all
	end

	assign apb_access = psel && penable && !pready_reg;
	assign apb_write  = apb_access && pwrite;
	assign apb_read   = apb_access && !pwrite;
	assign addr_ok    = addr_mapped(paddr);
	assign psr_sel    = (paddr == `ADDR_PSR);

	// Events: W1C from software, a fresh event wins over its own clear
	always @* begin
		evt_status_next = evt_status_reg;
		if (apb_write && (paddr == `ADDR_EVT_STATUS)) begin
			evt_status_next = evt_status_reg & ~pwdata[`EVT_W-1:0];
		end
		if (clamp_event) begin
			evt_status_next[`EVT_CLAMP_BIT] = 1'b1;
		end
		if (op_valid && is_field_op && field_bad) begin
			evt_status_next[`EVT_BAD_FIELD_BIT] = 1'b1;
		end
		if (status_write_op) begin
			evt_status_next[`EVT_STATUS_WRITE_BIT] = 1'b1;
		end
	end

	always @(posedge sys_clk) begin
		if (!resetn) begin
			psr_reg         <= `PSR_RESET;
			evt_status_reg  <= `EVT_STATUS_RESET;
			evt_mask_reg    <= `EVT_MASK_RESET;
			last_result_reg <= {DATA_W{1'b0}};
			irq_reg         <= 1'b0;
			valid_reg       <= 1'b0;
		end else begin
			psr_reg        <= psr_next;
			evt_status_reg <= evt_status_next;
			irq_reg        <= |(evt_status_next & evt_mask_reg);
			valid_reg      <= op_result_valid;
			if (op_result_valid) begin
				last_result_reg <= op_result;
			end
			if (apb_write && (paddr == `ADDR_EVT_MASK)) begin
				evt_mask_reg <= pwdata[`EVT_W-1:0];
			end
		end
	end

	// APB slave: access phase always stretched by one cycle, unmapped gives pslverr
	always @(posedge sys_clk) begin
		if (!resetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= apb_access;
			pslverr_reg <= apb_access && !addr_ok;
			prdata_reg  <= 32'h00000000;
			if (apb_read) begin
				case (paddr)
					`ADDR_PSR:         prdata_reg <= {{(32-`PSR_W){1'b0}}, psr_reg};
					`ADDR_EVT_STATUS:  prdata_reg <= {{(32-`EVT_W){1'b0}}, evt_status_reg};
					`ADDR_EVT_MASK:    prdata_reg <= {{(32-`EVT_W){1'b0}}, evt_mask_reg};
					`ADDR_LAST_RESULT: prdata_reg <= last_result_reg[31:0];
					default:           prdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	assign program_status_flags = psr_reg;
	assign prdata               = prdata_reg;
	assign pready               = pready_reg;
	assign pslverr              = pslverr_reg;
	assign irq                  = irq_reg;
endmodule

//--- design/bfx_consts.vh
// Purpose: Shared constants for the bitfield and extend datapath slice
// Assumes: 32-bit APB slave, byte addresses, one aligned word per register
// Notes: Opcode codes, register offsets, field positions and reset values
`ifndef BFX_CONSTS_VH
`define BFX_CONSTS_VH

`define OPC_W                       4
`define OPC_NONE                    4'h0
`define OPC_FIELD_CLEAR             4'h1
`define OPC_FIELD_INSERT            4'h2
`define OPC_SIGNED_FIELD_EXTRACT    4'h3
`define OPC_UNSIGNED_FIELD_EXTRACT  4'h4
`define OPC_SIGNED_BYTE_EXTEND      4'h5
`define OPC_UNSIGNED_BYTE_EXTEND    4'h6
`define OPC_SIGNED_HALF_EXTEND      4'h7
`define OPC_UNSIGNED_HALF_EXTEND    4'h8

`define ADDR_PSR                    8'h00
`define ADDR_EVT_STATUS             8'h04
`define ADDR_EVT_MASK               8'h08
`define ADDR_LAST_RESULT            8'h0C

`define PSR_W                       5
`define PSR_Q_BIT                   0
`define PSR_NZCV_LSB                1
`define PSR_RESET                   5'h00

`define EVT_W                       3
`define EVT_CLAMP_BIT               0
`define EVT_BAD_FIELD_BIT           1
`define EVT_STATUS_WRITE_BIT        2
`define EVT_STATUS_RESET            3'h0
`define EVT_MASK_RESET              3'h0

`endif

//--- design/field_mask_gen.v
// Purpose: Builds a contiguous bit mask from a start position and width
// Assumes: Width 1..32 and start plus width no more than 32
// Notes: Also flags a field that runs past bit 31 or has zero width
`timescale 1ns/1ps
module field_mask_gen #(
	parameter DATA_W = 32
) (
	input  wire [4:0]        field_lsb,
	input  wire [5:0]        field_width,
	output wire [DATA_W-1:0] field_mask,
	output wire              field_bad
);
	wire [DATA_W:0] ones;
	wire [6:0]      field_end;

	// One extra bit so a full 32-bit width does not wrap to zero
	assign ones       = ({{DATA_W{1'b0}}, 1'b1} << field_width) - {{DATA_W{1'b0}}, 1'b1};
	assign field_mask = ones[DATA_W-1:0] << field_lsb;
	assign field_end  = {2'b00, field_lsb} + {1'b0, field_width};
	assign field_bad  = (field_width == 6'h00) || (field_end > 7'h20);
endmodule

//--- design/rotate_extend.v
// Purpose: Rotates a source right by whole bytes, then byte or half extends it
// Assumes: Rotation in byte units, 0 means no rotation
// Notes: Pure combinational, no flags produced
`timescale 1ns/1ps
module rotate_extend (
	input  wire [31:0] extend_source_operand,
	input  wire [1:0]  rotate_right_amount,
	input  wire        extend_half,
	input  wire        extend_signed,
	output reg  [31:0] extend_result
);
	reg [31:0] rotated;

	always @* begin
		case (rotate_right_amount)
			2'h1:    rotated = {extend_source_operand[7:0], extend_source_operand[31:8]};
			2'h2:    rotated = {extend_source_operand[15:0], extend_source_operand[31:16]};
			2'h3:    rotated = {extend_source_operand[23:0], extend_source_operand[31:24]};
			default: rotated = extend_source_operand;
		endcase
		if (extend_half) begin
			extend_result = {{16{extend_signed & rotated[15]}}, rotated[15:0]};
		end else begin
			extend_result = {{24{extend_signed & rotated[7]}}, rotated[7:0]};
		end
	end
endmodule

//--- testbench/bitfield_extend_datapath_chk.sv
// Purpose: Port-level checks on the bitfield and extend slice
// Assumes: Bound into bitfield_extend_datapath
// Notes: Flag holds skip every bus cycle, since any may target the flags
`timescale 1ns/1ps
module bitfield_extend_datapath_chk (
	input wire        sys_clk,
	input wire        resetn,
	input wire        op_valid,
	input wire [3:0]  op_code,
	input wire [31:0] dest_operand,
	input wire [31:0] extend_source_operand,
	input wire [4:0]  field_lsb,
	input wire [5:0]  field_width,
	input wire [1:0]  rotate_right_amount,
	input wire [31:0] op_result,
	input wire        op_result_valid,
	input wire        clamp_valid,
	input wire        clamp_saturated,
	input wire        status_write_op,
	input wire [4:0]  program_status_flags,
	input wire        psel,
	input wire        penable,
	input wire        pready
);
	wire [32:0] ones  = (33'h1 << field_width) - 33'h1;
	wire [31:0] fmask = ones[31:0] << field_lsb;
	wire [63:0] rot   = {extend_source_operand, extend_source_operand} >> {rotate_right_amount, 3'b000};
	wire        quiet = !status_write_op && !psel;
	sequence sat_s; clamp_valid && clamp_saturated; endsequence
	sequence acc_s; psel && penable && !pready; endsequence
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	res_valid_a: assert property (op_result_valid == (op_valid && op_code != 4'h0))
		else $error("result valid wrong");
	nzcv_hold_a: assert property (quiet |=> $stable(program_status_flags[4:1]))
		else $error("condition flags moved");
	q_set_a: assert property (sat_s |=> program_status_flags[0])
		else $error("clamp did not set sticky bit");
	q_hold_a: assert property (quiet && !(clamp_valid && clamp_saturated) |=> $stable(program_status_flags[0]))
		else $error("sticky bit moved");
	field_clear_a: assert property (op_valid && op_code == 4'h1 |-> op_result == (dest_operand & ~fmask))
		else $error("field clear wrong");
	low_byte_a: assert property (op_valid && op_code >= 4'h5 && op_code <= 4'h8 |-> op_result[7:0] == rot[7:0])
		else $error("rotated byte wrong");
	sbyte_a: assert property (op_valid && op_code == 4'h5 |-> op_result[31:8] == {24{rot[7]}})
		else $error("signed byte upper wrong");
	ubyte_a: assert property (op_valid && op_code == 4'h6 |-> op_result[31:8] == 24'h0)
		else $error("unsigned byte upper wrong");
	shalf_a: assert property (op_valid && op_code == 4'h7 |-> op_result == {{16{rot[15]}}, rot[15:0]})
		else $error("signed half wrong");
	uhalf_a: assert property (op_valid && op_code == 4'h8 |-> op_result == {16'h0, rot[15:0]})
		else $error("unsigned half wrong");
	bus_wait_a: assert property (acc_s |=> pready ##1 !pready)
		else $error("bus answer timing wrong");
endmodule
bind bitfield_extend_datapath bitfield_extend_datapath_chk u_chk (.sys_clk, .resetn, .op_valid, .op_code,
	.dest_operand, .extend_source_operand, .field_lsb, .field_width, .rotate_right_amount, .op_result,
	.op_result_valid, .clamp_valid, .clamp_saturated, .status_write_op, .program_status_flags, .psel,
	.penable, .pready);

//--- testbench/regfile_model.sv
// Purpose: Register file that feeds destination values and takes writeback
// Assumes: Index below 13 always
// Notes: Stack pointer and PC are left out, so they can never be chosen
`timescale 1ns/1ps
module regfile_model (
	input  wire        sys_clk,
	input  wire        wr_en,
	input  wire [3:0]  wr_idx,
	input  wire [31:0] wr_data,
	input  wire [3:0]  rd_idx,
	output wire [31:0] rd_data
);
	reg     [31:0] gpr [0:12];
	integer        k;
	initial for (k = 0; k < 13; k = k + 1) gpr[k] = 32'h0;
	always @(posedge sys_clk) if (wr_en) gpr[wr_idx] <= wr_data;
	assign rd_data = gpr[rd_idx];
endmodule

//--- testbench/bitfield_extend_datapath_bench.sv
// Purpose: Self-checking bench for the bitfield and extend slice
// Assumes: Datapath result settles before the falling edge
// Notes: Random and directed fields stay legal; one deliberate out-of-range field raises the bad-field event
`timescale 1ns/1ps
`include "bfx_consts.vh"
`define CHK(a, b) begin samples_checked = samples_checked + 1; if ((a) !== (b)) begin \
	n_fail = n_fail + 1; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module bitfield_extend_datapath_bench;
	reg         sys_clk, resetn, op_valid, clamp_valid, clamp_saturated, status_write_op;
	reg         psel, penable, pwrite, er;
	reg  [3:0]  op_code, rd_idx;
	reg  [31:0] source_operand, extend_source_operand, pwdata, rd, exp_last;
	reg  [4:0]  field_lsb, status_write_data, f0;
	reg  [5:0]  field_width;
	reg  [1:0]  rotate_right_amount;
	reg  [7:0]  paddr;
	wire [31:0] dest_operand, op_result, prdata;
	wire [4:0]  program_status_flags;
	wire        op_result_valid, pready, pslverr, irq;
	integer     n_fail, samples_checked, cyc, i, c, l, seed;
	bitfield_extend_datapath u_dut (.sys_clk, .resetn, .op_valid, .op_code, .source_operand, .dest_operand,
		.extend_source_operand, .field_lsb, .field_width, .rotate_right_amount, .op_result, .op_result_valid,
		.clamp_valid, .clamp_saturated, .status_write_op, .status_write_data, .program_status_flags, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
	regfile_model u_rf (.sys_clk, .wr_en(op_result_valid), .wr_idx(rd_idx), .wr_data(op_result), .rd_idx,
		.rd_data(dest_operand));
	function [31:0] expect_res(input [3:0] oc, input [31:0] s, d, e, input [4:0] fl, input [5:0] w, input [1:0] r);
		reg [31:0] m, f;
		reg [63:0] t;
		begin
			m = ((33'h1 << w) - 33'h1) << fl;
			f = (s & m) >> fl;
			t = {e, e} >> {r, 3'b000};
			case (oc)
				4'h1: expect_res = d & ~m;
				4'h2: expect_res = (d & ~m) | ((s << fl) & m);
				4'h3: expect_res = f | ({32{f[w - 1]}} << w);
				4'h4: expect_res = f;
				4'h5: expect_res = {{24{t[7]}}, t[7:0]};
				4'h6: expect_res = {24'h0, t[7:0]};
				4'h7: expect_res = {{16{t[15]}}, t[15:0]};
				default: expect_res = {16'h0, t[15:0]};
			endcase
		end
	endfunction
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", samples_checked, n_fail);
			if (n_fail == 0 && samples_checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task run_op(input [3:0] oc, input [4:0] fl, input [5:0] w, input [1:0] r);
		begin
			op_valid <= 1'b1;
			op_code <= oc;
			field_lsb <= fl;
			field_width <= w;
			rotate_right_amount <= r;
			source_operand <= $random(seed);
			extend_source_operand <= $random(seed);
			rd_idx <= {$random(seed)} % 13;
			@(negedge sys_clk);
			exp_last = expect_res(oc, source_operand, dest_operand, extend_source_operand, fl, w, r);
			`CHK(op_result, exp_last)
			`CHK(op_result_valid, 1'b1)
			@(posedge sys_clk);
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge sys_clk);
			penable <= 1'b1;
			@(posedge sys_clk);
			while (pready !== 1'b1) @(posedge sys_clk);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge sys_clk);
		end
	endtask
	initial begin
		sys_clk = 0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Ceiling sits far above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail = n_fail + 1;
			print_verdict;
		end
	end
	initial begin
		{op_valid, clamp_valid, clamp_saturated, status_write_op, psel, penable, pwrite} = 0;
		{op_code, rd_idx, source_operand, extend_source_operand, pwdata, paddr} = 0;
		{field_lsb, field_width, rotate_right_amount, status_write_data} = 0;
		{n_fail, samples_checked, cyc, resetn} = 0;
		seed = 32'h4C4F87EA;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		`CHK(program_status_flags, `PSR_RESET)
		`CHK(irq, 1'b0)
		$display("reset test done");
		for (c = 1; c <= 8; c = c + 1)
			for (i = 0; i < 4; i = i + 1)
				run_op(c, i == 0 ? 0 : i == 1 ? 31 : i == 2 ? 8 : 20, i == 0 ? 32 : i == 1 ? 1 : i == 2 ? 12 : 4, i);
		f0 = program_status_flags;
		for (i = 0; i < 150; i = i + 1) begin
			l = {$random(seed)} % 32;
			run_op(1 + {$random(seed)} % 8, l, 1 + {$random(seed)} % (32 - l), $random(seed));
		end
		op_valid <= 1'b0;
		@(negedge sys_clk);
		`CHK(op_result_valid, 1'b0)
		`CHK(program_status_flags, f0)
		@(posedge sys_clk);
		apb(1'b0, `ADDR_LAST_RESULT, 32'h0);
		`CHK(rd, exp_last)
		// Deliberately out-of-range field to raise the bad-field event
		op_valid <= 1'b1;
		op_code <= `OPC_UNSIGNED_FIELD_EXTRACT;
		field_lsb <= 5'h1F;
		field_width <= 6'h02;
		@(posedge sys_clk);
		op_valid <= 1'b0;
		$display("datapath test done");
		@(posedge sys_clk);
		status_write_op <= 1'b1;
		status_write_data <= 5'h1E;
		@(posedge sys_clk);
		status_write_op <= 1'b0;
		clamp_valid <= 1'b1;
		@(posedge sys_clk);
		clamp_saturated <= 1'b1;
		@(negedge sys_clk);
		`CHK(program_status_flags, 5'h1E)
		@(posedge sys_clk);
		clamp_valid <= 1'b0;
		@(negedge sys_clk);
		`CHK(program_status_flags, 5'h1F)
		`CHK(irq, 1'b0)
		@(posedge sys_clk);
		apb(1'b1, `ADDR_EVT_MASK, 32'h1);
		@(negedge sys_clk);
		`CHK(irq, 1'b1)
		@(posedge sys_clk);
		apb(1'b0, `ADDR_EVT_STATUS, 32'h0);
		`CHK(rd, 32'h7)
		apb(1'b1, `ADDR_EVT_STATUS, 32'h5);
		`CHK(irq, 1'b0)
		apb(1'b0, `ADDR_EVT_STATUS, 32'h0);
		`CHK(rd, 32'h2)
		apb(1'b0, 8'h20, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		apb(1'b1, `ADDR_PSR, 32'h0);
		`CHK(program_status_flags, 5'h00)
		$display("flag and bus test done");
		apb(1'b1, `ADDR_EVT_MASK, 32'h7);
		status_write_op <= 1'b1;
		status_write_data <= 5'h1F;
		@(posedge sys_clk);
		status_write_op <= 1'b0;
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		`CHK(program_status_flags, `PSR_RESET)
		`CHK(irq, 1'b0)
		apb(1'b0, `ADDR_EVT_MASK, 32'h0);
		`CHK(rd, 32'h0)
		$display("mid-run reset test done");
		print_verdict;
	end
endmodule
